/* hw/issp_pkg.sv */
// Summary of operation
// - slave works only with mode field 110 and interface enable set.
// - START, SDA falling while SCL high, sets the bus busy flag.
// - first seven bits after START, MSB first, form the calling address.
// - address equal to own address sets match flag and raises interrupt request.
// - eighth bit after START goes to read/write flag; one means master reads.
// - after an address match the slave drives ACK low on the ninth bit.
// - direction control one means transmit, zero means receive; software sets it.
// - after a match SCL is held low until data write or dummy read.
// - data bytes are eight bits, MSB first, after address acknowledge.
// - the receiving side drives the ninth-bit ACK or NACK after each eight data bits.
// - when receiving, the transmit-ack control bit goes on SDA at ninth clock.
// - when transmitting, the master's ninth-clock ack is stored in received ack.
// - as transmitter, a missing ack stops sending and releases SDA.
// - with wake-on-match set, an address match wakes the chip.
// - interrupt request on address match, byte complete or bus time-out.
// - time-out counter starts on START plus match; SCL falling clears it.
// - count passing the period before SCL falls declares time-out, resets bus logic.
// - time-out counting stops when STOP is detected.
// - transfer-complete flag low while a byte moves, high with interrupt after.
// - own address sits in bits 7 to 1; bit 0 not compared.
// - time-out period is (select plus one) times 32 sub-clock periods.
// - on time-out counter stops, enable clears, flag sets, status resets.
package issp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_OWN = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0C;
	localparam logic [7:0] OFF_TMO = 8'h10;
	localparam logic [7:0] OFF_IEN = 8'h14;
	localparam logic [2:0] MODE_I2C = 3'h6;
	localparam int MODE_LSB = 5;
	localparam int B_EN = 1;
	localparam logic [7:0] CTRL_RST = 8'hE0;
	localparam logic [7:0] CTRL_WM = 8'hEF;
	localparam logic [7:0] STAT_RST = 8'h81;
	localparam logic [7:0] STAT_SWM = 8'h1A;
	localparam int B_HCF = 7;
	localparam int B_ADDRESS_MATCH_FLAG = 6;
	localparam int B_HBB = 5;
	localparam int B_HTX = 4;
	localparam int B_TRANSMIT_ACK_CONTROL = 3;
	localparam int B_SRW = 2;
	localparam int B_WAKE = 1;
	localparam int B_RECEIVED_ACK_FLAG = 0;
	localparam int B_TEN = 7;
	localparam int B_TOF = 6;
	localparam int TSEL_W = 6;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [3:0] BITS = 4'h8;
	localparam int TMO_UNIT = 32;
	localparam int TMO_CW = 12;
	localparam logic [2:0] SYNC_RST = 3'h3;
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ADDR = 4'h1,
		S_AACK = 4'h3,
		S_HOLD = 4'h2,
		S_RX = 4'h6,
		S_RACK = 4'h7,
		S_TX = 4'h5,
		S_TACK = 4'h4,
		S_WSTOP = 4'hC
	} issp_state_e;
endpackage

/* hw/issp_ln_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface issp_ln_if;
	logic scl;
	logic sda;
	logic start;
	logic stop;
	logic scl_rise;
	logic scl_fall;
	logic sub_rise;
	modport src(output scl, sda, start, stop, scl_rise, scl_fall, sub_rise);
	modport snk(input scl, sda, start, stop, scl_rise, scl_fall, sub_rise);
endinterface
`default_nettype wire

/* hw/issp_lnsync.sv */
`timescale 1ns/1ps
`default_nettype none
module issp_lnsync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sub_i,
	issp_ln_if.src ln
);
	import issp_pkg::*;
	// bit 0 scl, bit 1 sda, bit 2 sub-clock
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] s3_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= SYNC_RST;
			s2_q <= SYNC_RST;
			s3_q <= SYNC_RST;
		end else begin
			s1_q <= {sub_i, sda_i, scl_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign ln.scl = s2_q[0];
	assign ln.sda = s2_q[1];
	assign ln.start = s2_q[0] & s3_q[0] & s3_q[1] & ~s2_q[1];
	assign ln.stop = s2_q[0] & s3_q[0] & ~s3_q[1] & s2_q[1];
	assign ln.scl_rise = s2_q[0] & ~s3_q[0];
	assign ln.scl_fall = ~s2_q[0] & s3_q[0];
	assign ln.sub_rise = s2_q[2] & ~s3_q[2];
endmodule
`default_nettype wire

/* hw/issp_tmo.sv */
`timescale 1ns/1ps
`default_nettype none
module issp_tmo #(
	parameter int CW = issp_pkg::TMO_CW
) (
	input wire logic clk,
	input wire logic rst_n,
	issp_ln_if.snk ln,
	input wire logic arm,
	input wire logic en,
	input wire logic [issp_pkg::TSEL_W-1:0] sel,
	output logic fire
);
	import issp_pkg::*;
	logic run_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] lim;
	assign lim = CW'((32'(sel) + 32'd1) * TMO_UNIT);
	assign fire = run_q & en & (cnt_q >= lim);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			cnt_q <= '0;
		end else if (!en || fire || ln.stop) begin
			run_q <= 1'b0;
			cnt_q <= '0;
		end else if (arm) begin
			run_q <= 1'b1;
			cnt_q <= '0;
		end else if (ln.scl_fall) begin
			cnt_q <= '0;
		end else if (run_q && ln.sub_rise) begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
endmodule
`default_nettype wire

/* hw/issp_i2c_slave.sv */
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module issp_i2c_slave (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [issp_pkg::ADDR_W-1:0] PADDR,
	input wire logic [issp_pkg::DATA_W-1:0] PWDATA,
	output logic [issp_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic FSUB_I,
	output logic IRQ,
	output logic WAKE
);
	import issp_pkg::*;

	issp_ln_if ln();
	issp_state_e st_q;
	issp_state_e st_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] sh_q;
	logic [7:0] sh_d;
	logic [7:0] ctrl_q;
	logic [7:0] stat_q;
	logic [7:0] stat_d;
	logic [7:0] own_q;
	logic [7:0] data_q;
	logic [7:0] tmo_q;
	logic [7:0] tmo_d;
	logic ien_q;
	logic irq_q;
	logic wake_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic [DATA_W-1:0] prdata_q;
	logic match_ev;
	logic byte_ev;
	logic rx_end;
	logic tmo_ev;

	// ----------------------------------------------------------------
	// pin sampling and time-out
	// ----------------------------------------------------------------
	issp_lnsync u_sync (
		.clk(REF_CLK),
		.rst_n(NRST),
		.scl_i(SCL_I),
		.sda_i(SDA_I),
		.sub_i(FSUB_I),
		.ln(ln.src)
	);

	issp_tmo u_tmo (
		.clk(REF_CLK),
		.rst_n(NRST),
		.ln(ln.snk),
		.arm(match_ev),
		.en(tmo_q[B_TEN]),
		.sel(tmo_q[TSEL_W-1:0]),
		.fire(tmo_ev)
	);

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire logic acc = PSEL & PENABLE;
	wire logic wr = acc & PWRITE;
	wire logic rd = acc & ~PWRITE;
	wire logic sel_ctrl = PADDR == OFF_CTRL;
	wire logic sel_stat = PADDR == OFF_STAT;
	wire logic sel_own = PADDR == OFF_OWN;
	wire logic sel_data = PADDR == OFF_DATA;
	wire logic sel_tmo = PADDR == OFF_TMO;
	wire logic sel_ien = PADDR == OFF_IEN;
	wire logic mapped = sel_ctrl | sel_stat | sel_own | sel_data | sel_tmo | sel_ien;
	wire logic wr_data = wr & sel_data;
	wire logic rd_data = rd & sel_data;
	wire logic [7:0] rd_byte = sel_ctrl ? ctrl_q :
		sel_stat ? stat_q :
		sel_own ? own_q :
		sel_data ? data_q :
		sel_tmo ? tmo_q :
		sel_ien ? {7'h00, ien_q} : 8'h00;
	assign PREADY = 1'b1;
	assign PSLVERR = acc & ~mapped;
	assign PRDATA = prdata_q;

	// ----------------------------------------------------------------
	// bus state
	// ----------------------------------------------------------------
	wire logic active = (ctrl_q[MODE_LSB+:3] == MODE_I2C) & ctrl_q[B_EN];
	wire logic addr_hit = sh_q[7:1] == own_q[7:1];
	wire logic transmit_direction_control = stat_q[B_HTX];
	// software access that lets a held SCL go
	wire logic rel = (st_q == S_HOLD) & (transmit_direction_control ? wr_data : rd_data);
	wire logic quiet = active & ~ln.start & ~ln.stop & ~tmo_ev;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		match_ev = 1'b0;
		byte_ev = 1'b0;
		rx_end = 1'b0;
		if (!active || tmo_ev) begin
			st_d = S_IDLE;
		end else if (ln.stop) begin
			st_d = S_IDLE;
		end else if (ln.start) begin
			st_d = S_ADDR;
			cnt_d = 4'h0;
		end else begin
			case (st_q)
				S_ADDR, S_RX: begin
					if (ln.scl_rise) begin
						sh_d = {sh_q[6:0], ln.sda};
						cnt_d = cnt_q + 4'h1;
					end else if (ln.scl_fall && cnt_q == BITS) begin
						cnt_d = 4'h0;
						if (st_q == S_RX) begin
							rx_end = 1'b1;
							byte_ev = 1'b1;
							st_d = S_RACK;
						end else if (addr_hit) begin
							match_ev = 1'b1;
							st_d = S_AACK;
						end else begin
							st_d = S_WSTOP;
						end
					end
				end
				S_AACK, S_RACK: begin
					if (ln.scl_fall) begin
						st_d = S_HOLD;
					end
				end
				S_HOLD: begin
					if (rel) begin
						cnt_d = 4'h0;
						if (transmit_direction_control) begin
							sh_d = PWDATA[7:0];
							st_d = S_TX;
						end else begin
							st_d = S_RX;
						end
					end
				end
				S_TX: begin
					if (ln.scl_fall) begin
						sh_d = {sh_q[6:0], 1'b0};
						cnt_d = cnt_q + 4'h1;
						if (cnt_q == BITS - 4'h1) begin
							st_d = S_TACK;
						end
					end
				end
				S_TACK: begin
					if (ln.scl_fall) begin
						byte_ev = 1'b1;
						// a missing ack ends sending
						st_d = stat_q[B_RECEIVED_ACK_FLAG] ? S_WSTOP : S_HOLD;
					end
				end
				S_WSTOP: begin
					st_d = S_WSTOP;
				end
				default: begin
					st_d = S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status and time-out control
	// ----------------------------------------------------------------
	always_comb begin
		stat_d = stat_q;
		if (wr && sel_stat) begin
			stat_d = (stat_q & ~STAT_SWM) | (PWDATA[7:0] & STAT_SWM);
		end
		if (ln.start) begin
			stat_d[B_HBB] = 1'b1;
			stat_d[B_ADDRESS_MATCH_FLAG] = 1'b0;
			stat_d[B_HCF] = 1'b0;
		end
		if (ln.stop) begin
			stat_d[B_HBB] = 1'b0;
		end
		if (rel) begin
			stat_d[B_HCF] = 1'b0;
		end
		if (match_ev) begin
			stat_d[B_ADDRESS_MATCH_FLAG] = 1'b1;
			stat_d[B_SRW] = sh_q[0];
			stat_d[B_HCF] = 1'b1;
		end
		if (byte_ev) begin
			stat_d[B_HCF] = 1'b1;
		end
		if (st_q == S_TACK && ln.scl_rise) begin
			stat_d[B_RECEIVED_ACK_FLAG] = ln.sda;
		end
		if (!active) begin
			stat_d = (stat_d & STAT_SWM) | (STAT_RST & ~STAT_SWM);
		end
		if (tmo_ev) begin
			stat_d = STAT_RST;
		end
	end

	always_comb begin
		tmo_d = tmo_q;
		if (wr && sel_tmo) begin
			tmo_d = PWDATA[7:0];
		end
		// the time-out event wins over a software write
		if (tmo_ev) begin
			tmo_d[B_TEN] = 1'b0;
			tmo_d[B_TOF] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	wire logic scl_oe_d = st_d == S_HOLD;
	wire logic sda_oe_d = (st_d == S_AACK) |
		((st_d == S_RACK) & ~stat_d[B_TRANSMIT_ACK_CONTROL]) |
		((st_d == S_TX) & ~sh_d[7]);
	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign SCL_OE = scl_oe_q;
	assign SDA_OE = sda_oe_q;
	assign IRQ = irq_q;
	assign WAKE = wake_q;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			st_q <= S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= REG_RST;
			stat_q <= STAT_RST;
			tmo_q <= REG_RST;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			stat_q <= stat_d;
			tmo_q <= tmo_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_q <= CTRL_RST;
			own_q <= REG_RST;
			ien_q <= 1'b0;
		end else if (wr) begin
			if (sel_ctrl) begin
				ctrl_q <= PWDATA[7:0] & CTRL_WM;
			end
			if (sel_own) begin
				own_q <= PWDATA[7:0];
			end
			if (sel_ien) begin
				ien_q <= PWDATA[0];
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			data_q <= REG_RST;
		end else if (rx_end) begin
			data_q <= sh_q;
		end else if (wr_data) begin
			data_q <= PWDATA[7:0];
		end
	end

	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			irq_q <= 1'b0;
			wake_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			irq_q <= ien_q & (match_ev | byte_ev | tmo_ev);
			wake_q <= stat_q[B_WAKE] & match_ev;
			if (PSEL && !PENABLE) begin
				prdata_q <= {24'h000000, rd_byte};
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	sequence s_rx_end;
		quiet && st_q == S_RX && ln.scl_fall && cnt_q == BITS;
	endsequence
	sequence s_match;
		match_ev && !tmo_ev;
	endsequence

	property p_busy;
		ln.start && active && !tmo_ev |=> stat_q[B_HBB];
	endproperty
	a_busy: assert property (p_busy) else $error("busy flag not set on start");
	property p_off;
		!active |=> st_q == S_IDLE && stat_q[B_HCF] && !stat_q[B_HBB];
	endproperty
	a_off: assert property (p_off) else $error("disabled slave not idle");
	property p_match;
		s_match |=> stat_q[B_ADDRESS_MATCH_FLAG] && stat_q[B_SRW] == $past(sh_q[0]) && sda_oe_q;
	endproperty
	a_match: assert property (p_match) else $error("match flags or ack wrong");
	property p_ack;
		st_q == S_AACK |-> sda_oe_q;
	endproperty
	a_ack: assert property (p_ack) else $error("address ack not driven");
	property p_hold;
		st_q == S_HOLD && !rel && quiet |=> st_q == S_HOLD && scl_oe_q;
	endproperty
	a_hold: assert property (p_hold) else $error("scl released too early");
	property p_rack;
		st_q == S_RACK |-> sda_oe_q == !stat_q[B_TRANSMIT_ACK_CONTROL];
	endproperty
	a_rack: assert property (p_rack) else $error("receive ack wrong level");
	property p_nak;
		st_q == S_WSTOP |-> !sda_oe_q && !scl_oe_q;
	endproperty
	a_nak: assert property (p_nak) else $error("sda held after nack");
	property p_tmo;
		tmo_ev |=> stat_q == STAT_RST && !tmo_q[B_TEN] && tmo_q[B_TOF] && st_q == S_IDLE;
	endproperty
	a_tmo: assert property (p_tmo) else $error("time-out did not reset");
	property p_rxdone;
		s_rx_end |=> stat_q[B_HCF] && data_q == $past(sh_q) && irq_q == $past(ien_q);
	endproperty
	a_rxdone: assert property (p_rxdone) else $error("byte completion missed");
	property p_irq;
		(match_ev || byte_ev || tmo_ev) && ien_q |=> IRQ ##1 !IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt pulse wrong");
	property p_wake;
		match_ev && stat_q[B_WAKE] |=> WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake not raised");
endmodule
`default_nettype wire

/* tb/issp_mst_model.sv */
`timescale 1ns/1ps
`default_nettype none
module issp_mst_model (
	input wire logic clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// ----------------------------------------
	// bit level, one quarter is two clk cycles
	// ----------------------------------------
	task automatic q();
		repeat (2) @(posedge clk);
	endtask
	// data changes while scl is low; a held scl is waited out
	task automatic bitx(input logic b, output logic r);
		sda_oe <= ~b;
		q();
		scl_oe <= 1'b0;
		do @(posedge clk); while (scl !== 1'b1);
		@(posedge clk);
		r = sda;
		q();
		scl_oe <= 1'b1;
		q();
	endtask
	// only this side ever makes a start, from an idle bus
	task automatic start();
		sda_oe <= 1'b1;
		q();
		scl_oe <= 1'b1;
		q();
	endtask
	// also ends a transfer whose address was refused
	task automatic stop();
		sda_oe <= 1'b1;
		q();
		scl_oe <= 1'b0;
		do @(posedge clk); while (scl !== 1'b1);
		q();
		sda_oe <= 1'b0;
		q();
	endtask
	task automatic wr(input logic [7:0] x, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(x[i], r);
		end
		bitx(1'b1, ack_n);
	endtask
	task automatic rd(input logic nack, output logic [7:0] x);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			x[i] = r;
		end
		bitx(nack, r);
	endtask
endmodule
`default_nettype wire

/* tb/issp_i2c_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module issp_i2c_slave_tb;
	import issp_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, perr, err, irq, wake;
	logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, ack_n;
	logic [7:0] paddr, d;
	logic [31:0] pwdata, prdata, v;
	logic [3:0] fdiv;
	int mismatches, total_checks, irq_cnt, wake_cnt, i0;
	wire scl;
	wire sda;
	// open-drain lines with pull-ups
	assign scl = ~(scl_oe | m_scl_oe);
	assign sda = ~(sda_oe | m_sda_oe);
	issp_i2c_slave DUT (.REF_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(perr), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(),
		.SDA_OE(sda_oe), .FSUB_I(fdiv[1]), .IRQ(irq), .WAKE(wake));
	issp_mst_model m (.clk(clk), .scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// fast sub-clock keeps time-out periods short
	always @(posedge clk) begin
		fdiv <= fdiv + 4'h1;
		irq_cnt <= irq_cnt + (irq === 1'b1);
		wake_cnt <= wake_cnt + (wake === 1'b1);
	end
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		v = prdata;
		err = perr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wrr(input logic [7:0] a, input logic [7:0] x);
		apb(1'b1, a, {24'h0, x});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		chk(v & {24'h0, mk}, {24'h0, e});
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		close_out();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fdiv = 4'h0;
		irq_cnt = 0;
		wake_cnt = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rdc(OFF_CTRL, 8'hFF, CTRL_RST);
		rdc(OFF_STAT, 8'hFF, STAT_RST);
		rdc(OFF_TMO, 8'hFF, REG_RST);
		wrr(OFF_STAT, 8'hFF);
		rdc(OFF_STAT, 8'hFF, STAT_RST | STAT_SWM);
		wrr(OFF_STAT, 8'h00);
		rdc(8'h18, 8'hFF, 8'h00);
		chk(err, 1'b1);
		wrr(OFF_OWN, 8'hA5);
		rdc(OFF_OWN, 8'hFF, 8'hA5);
		m.start();
		m.wr(8'hA4, ack_n);
		chk(ack_n, 1'b1);
		m.stop();
		$display("test registers done");
		wrr(OFF_CTRL, {MODE_I2C, 5'h02});
		wrr(OFF_IEN, 8'h01);
		m.start();
		m.wr(8'hB0, ack_n);
		chk(ack_n, 1'b1);
		m.stop();
		rdc(OFF_STAT, 8'h40, 8'h00);
		$display("test mismatch done");
		m.start();
		repeat (4) @(posedge clk);
		rdc(OFF_STAT, 8'h20, 8'h20);
		i0 = irq_cnt;
		m.wr(8'hA4, ack_n);
		chk(ack_n, 1'b0);
		chk(irq_cnt > i0, 1'b1);
		rdc(OFF_STAT, 8'hE4, 8'hE0);
		chk(scl_oe, 1'b1);
		apb(1'b0, OFF_DATA, 32'h0);
		m.wr(8'h3C, ack_n);
		chk(ack_n, 1'b0);
		rdc(OFF_STAT, 8'h80, 8'h80);
		rdc(OFF_DATA, 8'hFF, 8'h3C);
		wrr(OFF_STAT, 8'h08);
		m.wr(8'hC3, ack_n);
		chk(ack_n, 1'b1);
		rdc(OFF_DATA, 8'hFF, 8'hC3);
		m.stop();
		$display("test slave receive done");
		wrr(OFF_TMO, 8'h81);
		wrr(OFF_STAT, 8'h12);
		i0 = wake_cnt;
		m.start();
		m.wr(8'hA5, ack_n);
		chk(ack_n, 1'b0);
		chk(wake_cnt > i0, 1'b1);
		rdc(OFF_STAT, 8'h44, 8'h44);
		wrr(OFF_DATA, 8'h96);
		m.rd(1'b0, d);
		chk(d, 8'h96);
		rdc(OFF_STAT, 8'h01, 8'h00);
		wrr(OFF_DATA, 8'h5A);
		m.rd(1'b1, d);
		chk(d, 8'h5A);
		rdc(OFF_STAT, 8'h01, 8'h01);
		repeat (4) @(posedge clk);
		chk(sda_oe, 1'b0);
		m.stop();
		repeat (400) @(posedge clk);
		rdc(OFF_TMO, 8'hFF, 8'h81);
		$display("test slave transmit done");
		wrr(OFF_STAT, 8'h00);
		m.start();
		m.wr(8'hA4, ack_n);
		i0 = irq_cnt;
		repeat (200) @(posedge clk);
		rdc(OFF_TMO, 8'hFF, 8'h81);
		chk(scl_oe, 1'b1);
		repeat (120) @(posedge clk);
		rdc(OFF_TMO, 8'hFF, 8'h41);
		rdc(OFF_STAT, 8'hFF, STAT_RST);
		chk(scl_oe, 1'b0);
		chk(irq_cnt > i0, 1'b1);
		m.stop();
		$display("test time-out done");
		close_out();
	end
endmodule
`default_nettype wire
